//--- hdl/fws_regs.svh
// Contract
// - engine code: 4096 words at 1024 times base
// - engine reads only; SPI needs program mode, halted
// - write and erase need key 0010
// - key kept until rewritten; programmer clears it
// - steer bit sends stores to flash, else RAM
// - steer bit clears after each flash byte
// - steer writes ignored with interrupts enabled
// - engine on: posted write defers, sets pending
// - engine pass end: pending drops, write happens
// - pending set: further processor flash writes discarded
// - erased byte reads ff; page or full erase
// - mass erase: arm, then aa, emulator enabled
// - page erase: page select, then 55
// - 64 cycle pre-boot interval before primary boot
// - first 32 cycles: emulator held, flag shown
// - security clears on reset, ones-only writes
// - secure: emulator bulk erase only, no reads
// - secure: no page erase of page zero
// - secure: no writes to page zero
// - secure: no page erase at or above engine code
// - security removed only by erase plus reset; here any reset clears it
// - SPI reaches flash array only
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH
// ==========================================
// device register map
`define FWS_ADDR_ERASE 16'h0094
`define FWS_ADDR_CTRL 16'h00b2
`define FWS_ADDR_PGSEL 16'h00b7
`define FWS_ADDR_BASE 16'h2109
`define FWS_ADDR_KEY 16'h2702
`define FWS_CTRL_STEER 0
`define FWS_CTRL_ARM 1
`define FWS_CTRL_POSTED 2
`define FWS_CTRL_PEND 3
`define FWS_CTRL_SECURE 6
`define FWS_CTRL_EARLY 7
`define FWS_PGSEL_LSB 2
`define FWS_KEY_LSB 4
`define FWS_KEY_VALUE 4'h2
`define FWS_KEY_RESET 4'h0
`define FWS_ERASE_MASS 8'haa
`define FWS_ERASE_PAGE 8'h55
`define FWS_ERASED 8'hff
`define FWS_PAGE_SHIFT 10
`define FWS_CE_WORDS 4096
`define FWS_EARLY_BOOT_FLAG_CYC 7'h40
`define FWS_EARLY_CYC 7'h20
// ==========================================
// controller registers and commands
`define FWS_H_CMD 4'h0
`define FWS_H_ADDR 4'h1
`define FWS_H_DATA 4'h2
`define FWS_H_STAT 4'h3
`define FWS_H_CERES 4'h4
`define FWS_C_UNLOCK 4'h0
`define FWS_C_LOCK 4'h1
`define FWS_C_WRITE 4'h2
`define FWS_C_PAGE 4'h3
`define FWS_C_MASS 4'h4
`define FWS_C_SECURE 4'h5
`define FWS_C_BASE 4'h6
`define FWS_C_FREAD 4'h7
`define FWS_C_CEREAD 4'h8
`define FWS_C_EXT 4'h9
`define FWS_C_RDREG 4'ha
`endif

//--- hdl/fws_pkg.sv
package fws_pkg;
  typedef enum logic [1:0] {FWS_OP_READ, FWS_OP_WRITE, FWS_OP_PAGE, FWS_OP_MASS} fws_op_type;
  typedef enum logic {FWS_SRC_EMU, FWS_SRC_SPI} fws_src_type;
  typedef enum logic [1:0] {FWS_H_IDLE, FWS_H_ST1, FWS_H_ST2, FWS_H_WAIT} fws_hstate_type;
endpackage : fws_pkg

//--- hdl/fws_if.sv
`timescale 1ns/1ps
interface fws_if;
  import fws_pkg::*;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_wr;
  logic cpu_rd;
  logic [7:0] cpu_rdata;
  logic cpu_movx;
  logic cpu_ea;
  logic cpu_frd;
  logic [15:0] cpu_faddr;
  logic [7:0] cpu_fdata;
  logic ram_wr;
  logic [15:0] ram_addr;
  logic [7:0] ram_data;
  logic ce_enable;
  logic ce_busy;
  logic ce_rd;
  logic [11:0] ce_idx;
  logic [15:0] ce_rdata;
  logic emu_en;
  logic emu_grant;
  logic production_program_mode;
  logic mpu_halted;
  logic ext_req;
  fws_src_type ext_src;
  fws_op_type ext_op;
  logic [15:0] ext_addr;
  logic [7:0] ext_wdata;
  logic ext_done;
  logic ext_refused;
  logic [7:0] ext_rdata;
  modport dev (
    input cpu_addr, cpu_wdata, cpu_wr, cpu_rd, cpu_movx, cpu_ea, cpu_frd, cpu_faddr,
    input ce_enable, ce_busy, ce_rd, ce_idx, emu_en, production_program_mode, mpu_halted,
    input ext_req, ext_src, ext_op, ext_addr, ext_wdata,
    output cpu_rdata, cpu_fdata, ram_wr, ram_addr, ram_data, ce_rdata, emu_grant,
    output ext_done, ext_refused, ext_rdata
  );
  modport host (
    output cpu_addr, cpu_wdata, cpu_wr, cpu_rd, cpu_movx, cpu_ea, cpu_frd, cpu_faddr,
    output ce_enable, ce_busy, ce_rd, ce_idx, emu_en, production_program_mode, mpu_halted,
    output ext_req, ext_src, ext_op, ext_addr, ext_wdata,
    input cpu_rdata, cpu_fdata, ram_wr, ram_addr, ram_data, ce_rdata, emu_grant,
    input ext_done, ext_refused, ext_rdata
  );
endinterface : fws_if

//--- hdl/fws_device.sv
`timescale 1ns/1ps
`include "fws_regs.svh"
module fws_device
  import fws_pkg::*;
#(
  parameter int FLASH_BYTES = 65536
) (
  input wire logic mclk,
  input wire logic resetn,
  fws_if.dev bus,
  output logic boot_done,
  output logic secure
);
  localparam int AW = $clog2(FLASH_BYTES);

  // ==========================================
  // helpers
  function automatic logic [5:0] page_of(input logic [15:0] a);
    return a[15:`FWS_PAGE_SHIFT];
  endfunction : page_of

  function automatic logic erase_locked(input logic [5:0] pg, input logic sec,
                                        input logic [5:0] base);
    return sec && (pg == 6'h00 || pg >= base);
  endfunction : erase_locked

  function automatic logic write_locked(input logic [15:0] a, input logic sec);
    return sec && page_of(a) == 6'h00;
  endfunction : write_locked

  // ==========================================
  // state
  logic [7:0] mem_r [FLASH_BYTES];
  logic steer_r;
  logic arm_r;
  logic posted_r;
  logic pend_r;
  logic secure_r;
  logic [5:0] pgsel_r;
  logic [5:0] base_r;
  logic [3:0] key_r;
  logic [15:0] pend_addr_r;
  logic [7:0] pend_data_r;
  logic ce_busy_r;
  logic [6:0] boot_cnt_r;
  logic [7:0] cpu_rdata_r;
  logic [7:0] cpu_fdata_r;
  logic [15:0] ce_rdata_r;
  logic ram_wr_r;
  logic [15:0] ram_addr_r;
  logic [7:0] ram_data_r;
  logic ext_done_r;
  logic ext_refused_r;
  logic [7:0] ext_rdata_r;

  // ==========================================
  // decode
  logic unlocked;
  logic early;
  logic wr_ctrl;
  logic wr_erase;
  logic wr_pgsel;
  logic wr_base;
  logic wr_key;
  logic st_flash;
  logic cpu_may;
  logic cpu_post;
  logic cpu_wr_now;
  logic post_fire;
  logic cpu_erase_ok;
  logic cpu_page;
  logic cpu_mass;
  logic src_ok;
  logic sec_ok;
  logic ext_ok;
  logic ext_rd;
  logic ext_wr;
  logic ext_page;
  logic ext_mass;
  logic ext_take;
  logic do_mass;
  logic do_page;
  logic do_wr;
  logic [5:0] erase_pg;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;
  logic [15:0] ce_a0;
  logic [15:0] ce_a1;
  logic [7:0] rd_mux;

  assign unlocked = key_r == `FWS_KEY_VALUE;
  assign early = boot_cnt_r < `FWS_EARLY_CYC;
  assign boot_done = boot_cnt_r >= `FWS_EARLY_BOOT_FLAG_CYC;
  assign secure = secure_r;
  assign wr_ctrl = bus.cpu_wr && bus.cpu_addr == `FWS_ADDR_CTRL;
  assign wr_erase = bus.cpu_wr && bus.cpu_addr == `FWS_ADDR_ERASE;
  assign wr_pgsel = bus.cpu_wr && bus.cpu_addr == `FWS_ADDR_PGSEL;
  assign wr_base = bus.cpu_wr && bus.cpu_addr == `FWS_ADDR_BASE;
  assign wr_key = bus.cpu_wr && bus.cpu_addr == `FWS_ADDR_KEY;

  // processor stores
  assign st_flash = bus.cpu_movx && steer_r;
  assign cpu_may = unlocked && !bus.production_program_mode && !write_locked(bus.cpu_addr, secure_r)
                   && !pend_r;
  assign cpu_post = st_flash && cpu_may && bus.ce_enable && posted_r;
  assign cpu_wr_now = st_flash && cpu_may && !bus.ce_enable;
  assign post_fire = pend_r && ce_busy_r && !bus.ce_busy;

  // processor erase sequences
  assign cpu_erase_ok = unlocked && !bus.ce_enable && !bus.production_program_mode;
  assign cpu_page = wr_erase && bus.cpu_wdata == `FWS_ERASE_PAGE && cpu_erase_ok
                    && !erase_locked(pgsel_r, secure_r, base_r);
  assign cpu_mass = wr_erase && bus.cpu_wdata == `FWS_ERASE_MASS && arm_r
                    && bus.emu_en && cpu_erase_ok;

  // emulator and SPI port, flash array only
  assign src_ok = (bus.ext_src == FWS_SRC_SPI) ? (bus.production_program_mode && bus.mpu_halted)
                                                : (bus.emu_en && !early);
  assign sec_ok = !secure_r || ((bus.ext_src == FWS_SRC_EMU) ? bus.ext_op == FWS_OP_MASS
                                                             : bus.ext_op != FWS_OP_READ);
  assign ext_ok = bus.ext_req && src_ok && sec_ok;
  assign ext_rd = ext_ok && bus.ext_op == FWS_OP_READ;
  assign ext_wr = ext_ok && bus.ext_op == FWS_OP_WRITE && unlocked
                  && !write_locked(bus.ext_addr, secure_r);
  assign ext_page = ext_ok && bus.ext_op == FWS_OP_PAGE && unlocked
                    && !erase_locked(page_of(bus.ext_addr), secure_r, base_r);
  assign ext_mass = ext_ok && bus.ext_op == FWS_OP_MASS && unlocked;
  assign ext_take = ext_rd || ext_wr || ext_page || ext_mass;

  // one flash operation per cycle, refused ones never get here
  assign do_mass = cpu_mass || ext_mass;
  assign do_page = cpu_page || ext_page;
  assign do_wr = post_fire || ext_wr || cpu_wr_now;
  assign erase_pg = ext_page ? page_of(bus.ext_addr) : pgsel_r;
  assign wr_addr = post_fire ? pend_addr_r : (ext_wr ? bus.ext_addr : bus.cpu_addr);
  assign wr_data = post_fire ? pend_data_r : (ext_wr ? bus.ext_wdata : bus.cpu_wdata);

  // engine word fetch inside its own code window
  assign ce_a0 = {base_r, 10'h000} + {3'b000, bus.ce_idx, 1'b0};
  assign ce_a1 = ce_a0 + 16'h0001;

  always_comb begin
    rd_mux = 8'h00;
    case (bus.cpu_addr)
      `FWS_ADDR_CTRL: begin
        rd_mux[`FWS_CTRL_STEER] = steer_r;
        rd_mux[`FWS_CTRL_ARM] = arm_r;
        rd_mux[`FWS_CTRL_POSTED] = posted_r;
        rd_mux[`FWS_CTRL_PEND] = pend_r;
        rd_mux[`FWS_CTRL_SECURE] = secure_r;
        rd_mux[`FWS_CTRL_EARLY] = early;
      end
      `FWS_ADDR_PGSEL: rd_mux = {pgsel_r, 2'b00};
      `FWS_ADDR_BASE: rd_mux = {2'b00, base_r};
      `FWS_ADDR_KEY: rd_mux = {key_r, 4'h0};
      default: rd_mux = 8'h00;
    endcase
  end

  assign bus.cpu_rdata = cpu_rdata_r;
  assign bus.cpu_fdata = cpu_fdata_r;
  assign bus.ce_rdata = ce_rdata_r;
  assign bus.ram_wr = ram_wr_r;
  assign bus.ram_addr = ram_addr_r;
  assign bus.ram_data = ram_data_r;
  assign bus.emu_grant = !early;
  assign bus.ext_done = ext_done_r;
  assign bus.ext_refused = ext_refused_r;
  assign bus.ext_rdata = ext_rdata_r;

  // ==========================================
  // flash array, non-volatile so no reset
  always_ff @(posedge mclk) begin
    for (int i = 0; i < FLASH_BYTES; i++) begin
      if (do_mass || (do_page && (i >> `FWS_PAGE_SHIFT) == int'(erase_pg))) begin
        mem_r[i] <= `FWS_ERASED;
      end else if (do_wr && i == int'(wr_addr[AW-1:0])) begin
        mem_r[i] <= wr_data;
      end
    end
  end

  // ==========================================
  // control registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      steer_r <= 1'b0;
      arm_r <= 1'b0;
      posted_r <= 1'b0;
      secure_r <= 1'b0;
      pgsel_r <= 6'h00;
      base_r <= 6'h00;
      key_r <= `FWS_KEY_RESET;
      boot_cnt_r <= 7'h00;
    end else begin
      if (wr_ctrl && !bus.cpu_ea) begin
        steer_r <= bus.cpu_wdata[`FWS_CTRL_STEER];
      end else if (st_flash) begin
        steer_r <= 1'b0;
      end
      if (wr_ctrl) begin
        arm_r <= bus.cpu_wdata[`FWS_CTRL_ARM];
        posted_r <= bus.cpu_wdata[`FWS_CTRL_POSTED];
      end else if (wr_erase) begin
        arm_r <= 1'b0;
      end
      if (wr_ctrl && bus.cpu_wdata[`FWS_CTRL_SECURE]) begin
        secure_r <= 1'b1;
      end
      if (wr_pgsel) begin
        pgsel_r <= bus.cpu_wdata[7:`FWS_PGSEL_LSB];
      end
      if (wr_base) begin
        base_r <= bus.cpu_wdata[5:0];
      end
      if (wr_key) begin
        key_r <= bus.cpu_wdata[7:`FWS_KEY_LSB];
      end
      if (!boot_done) begin
        boot_cnt_r <= boot_cnt_r + 7'h01;
      end
    end
  end

  // ==========================================
  // posted write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      pend_addr_r <= 16'h0000;
      pend_data_r <= 8'h00;
      ce_busy_r <= 1'b0;
    end else begin
      ce_busy_r <= bus.ce_busy;
      if (cpu_post) begin
        pend_r <= 1'b1;
        pend_addr_r <= bus.cpu_addr;
        pend_data_r <= bus.cpu_wdata;
      end else if (post_fire) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // read answers, valid only the cycle after the request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata_r <= 8'h00;
      cpu_fdata_r <= 8'h00;
      ce_rdata_r <= 16'h0000;
      ram_wr_r <= 1'b0;
      ram_addr_r <= 16'h0000;
      ram_data_r <= 8'h00;
      ext_done_r <= 1'b0;
      ext_refused_r <= 1'b0;
      ext_rdata_r <= 8'h00;
    end else begin
      cpu_rdata_r <= bus.cpu_rd ? rd_mux : 8'h00;
      cpu_fdata_r <= bus.cpu_frd ? mem_r[bus.cpu_faddr[AW-1:0]] : 8'h00;
      ce_rdata_r <= bus.ce_rd ? {mem_r[ce_a1[AW-1:0]], mem_r[ce_a0[AW-1:0]]} : 16'h0000;
      ram_wr_r <= bus.cpu_movx && !steer_r;
      ram_addr_r <= bus.cpu_addr;
      ram_data_r <= bus.cpu_wdata;
      ext_done_r <= ext_take;
      ext_refused_r <= bus.ext_req && !ext_take;
      ext_rdata_r <= ext_rd ? mem_r[bus.ext_addr[AW-1:0]] : 8'h00;
    end
  end
endmodule : fws_device

//--- hdl/fws_host.sv
`timescale 1ns/1ps
`include "fws_regs.svh"
module fws_host
  import fws_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  fws_if.host bus,
  input wire logic [3:0] usr_addr,
  input wire logic [15:0] usr_wdata,
  input wire logic usr_wr,
  input wire logic usr_rd,
  output logic [15:0] usr_rdata,
  input wire logic ea,
  input wire logic ce_enable,
  input wire logic ce_busy,
  input wire logic emu_en,
  input wire logic production_program_mode,
  input wire logic mpu_halted
);
  fws_hstate_type state_r;
  logic [3:0] cmd_r;
  logic [15:0] addr_r;
  logic [15:0] data_r;
  logic [7:0] res_r;
  logic [15:0] ce_res_r;
  logic refused_r;
  logic [15:0] usr_rdata_r;
  logic busy;
  logic start;

  assign busy = state_r != FWS_H_IDLE;
  assign start = usr_wr && usr_addr == `FWS_H_CMD && !busy;
  assign usr_rdata = usr_rdata_r;

  // ==========================================
  // environment and fixed fields
  assign bus.cpu_ea = ea;
  assign bus.ce_enable = ce_enable;
  assign bus.ce_busy = ce_busy;
  assign bus.emu_en = emu_en;
  assign bus.production_program_mode = production_program_mode;
  assign bus.mpu_halted = mpu_halted;
  assign bus.cpu_faddr = addr_r;
  assign bus.ce_idx = addr_r[11:0];
  assign bus.ext_addr = addr_r;
  assign bus.ext_wdata = data_r[7:0];
  assign bus.ext_op = fws_op_type'(data_r[9:8]);
  assign bus.ext_src = fws_src_type'(data_r[10]);

  // ==========================================
  // two-step sequences
  always_comb begin
    bus.cpu_addr = addr_r;
    bus.cpu_wdata = 8'h00;
    bus.cpu_wr = 1'b0;
    bus.cpu_rd = 1'b0;
    bus.cpu_movx = 1'b0;
    bus.cpu_frd = 1'b0;
    bus.ce_rd = 1'b0;
    bus.ext_req = 1'b0;
    if (state_r == FWS_H_ST1) begin
      bus.cpu_wr = 1'b1;
      case (cmd_r)
        `FWS_C_UNLOCK: begin
          bus.cpu_addr = `FWS_ADDR_KEY;
          bus.cpu_wdata = {`FWS_KEY_VALUE, 4'h0};
        end
        `FWS_C_LOCK: bus.cpu_addr = `FWS_ADDR_KEY;
        `FWS_C_WRITE: begin
          bus.cpu_addr = `FWS_ADDR_CTRL;
          bus.cpu_wdata[`FWS_CTRL_STEER] = 1'b1;
          bus.cpu_wdata[`FWS_CTRL_POSTED] = ce_enable;
        end
        `FWS_C_PAGE: begin
          bus.cpu_addr = `FWS_ADDR_PGSEL;
          bus.cpu_wdata = {addr_r[15:`FWS_PAGE_SHIFT], 2'b00};
        end
        `FWS_C_MASS: begin
          bus.cpu_addr = `FWS_ADDR_CTRL;
          bus.cpu_wdata[`FWS_CTRL_ARM] = 1'b1;
        end
        `FWS_C_SECURE: begin
          bus.cpu_addr = `FWS_ADDR_CTRL;
          bus.cpu_wdata[`FWS_CTRL_SECURE] = 1'b1;
        end
        `FWS_C_BASE: begin
          bus.cpu_addr = `FWS_ADDR_BASE;
          bus.cpu_wdata = data_r[7:0];
        end
        default: bus.cpu_wr = 1'b0;
      endcase
    end else if (state_r == FWS_H_ST2) begin
      case (cmd_r)
        `FWS_C_WRITE: begin
          bus.cpu_movx = 1'b1;
          bus.cpu_wdata = data_r[7:0];
        end
        `FWS_C_PAGE: begin
          bus.cpu_wr = 1'b1;
          bus.cpu_addr = `FWS_ADDR_ERASE;
          bus.cpu_wdata = `FWS_ERASE_PAGE;
        end
        `FWS_C_MASS: begin
          bus.cpu_wr = 1'b1;
          bus.cpu_addr = `FWS_ADDR_ERASE;
          bus.cpu_wdata = `FWS_ERASE_MASS;
        end
        `FWS_C_FREAD: bus.cpu_frd = 1'b1;
        `FWS_C_CEREAD: bus.ce_rd = 1'b1;
        `FWS_C_EXT: bus.ext_req = 1'b1;
        `FWS_C_RDREG: bus.cpu_rd = 1'b1;
        default: bus.cpu_rd = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= FWS_H_IDLE;
      cmd_r <= 4'h0;
      addr_r <= 16'h0000;
      data_r <= 16'h0000;
      res_r <= 8'h00;
      ce_res_r <= 16'h0000;
      refused_r <= 1'b0;
      usr_rdata_r <= 16'h0000;
    end else begin
      unique case (state_r)
        FWS_H_IDLE: if (start) state_r <= FWS_H_ST1;
        FWS_H_ST1: state_r <= FWS_H_ST2;
        FWS_H_ST2: state_r <= FWS_H_WAIT;
        FWS_H_WAIT: state_r <= FWS_H_IDLE;
      endcase
      if (start) cmd_r <= usr_wdata[3:0];
      if (usr_wr && usr_addr == `FWS_H_ADDR && !busy) addr_r <= usr_wdata;
      if (usr_wr && usr_addr == `FWS_H_DATA && !busy) data_r <= usr_wdata;
      if (state_r == FWS_H_WAIT) begin
        if (cmd_r == `FWS_C_FREAD) res_r <= bus.cpu_fdata;
        if (cmd_r == `FWS_C_RDREG) res_r <= bus.cpu_rdata;
        if (cmd_r == `FWS_C_CEREAD) ce_res_r <= bus.ce_rdata;
        if (cmd_r == `FWS_C_EXT) begin
          res_r <= bus.ext_rdata;
          refused_r <= bus.ext_refused;
        end
      end
      case (usr_addr)
        `FWS_H_ADDR: usr_rdata_r <= usr_rd ? addr_r : 16'h0000;
        `FWS_H_DATA: usr_rdata_r <= usr_rd ? data_r : 16'h0000;
        `FWS_H_STAT: usr_rdata_r <= usr_rd ? {busy, refused_r, 6'h00, res_r} : 16'h0000;
        `FWS_H_CERES: usr_rdata_r <= usr_rd ? ce_res_r : 16'h0000;
        default: usr_rdata_r <= 16'h0000;
      endcase
    end
  end
endmodule : fws_host

//--- bench/fws_properties.sv
`timescale 1ns/1ps
module fws_properties
  import fws_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic emu_grant,
  input wire logic production_program_mode,
  input wire logic mpu_halted,
  input wire logic ext_req,
  input fws_src_type ext_src,
  input fws_op_type ext_op,
  input wire logic [15:0] ext_addr,
  input wire logic ext_done,
  input wire logic ext_refused
);
  // ==========================================
  // shadow of key, base, secure bit and boot count
  logic [3:0] key_r;
  logic [5:0] base_r;
  logic sec_r;
  logic [6:0] boot_r;
  wire key_wr = cpu_wr && cpu_addr == 16'h2702;
  wire base_wr = cpu_wr && cpu_addr == 16'h2109;
  wire sec_wr = cpu_wr && cpu_addr == 16'h00b2 && cpu_wdata[6];
  wire emu_req = ext_req && ext_src == FWS_SRC_EMU;
  wire spi_req = ext_req && ext_src == FWS_SRC_SPI;
  wire page_hit = ext_op == FWS_OP_WRITE || ext_op == FWS_OP_PAGE;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      key_r <= 4'h0;
      base_r <= 6'h00;
      sec_r <= 1'b0;
      boot_r <= 7'h00;
    end else begin
      if (key_wr) key_r <= cpu_wdata[7:4];
      if (base_wr) base_r <= cpu_wdata[5:0];
      if (sec_wr) sec_r <= 1'b1;
      if (boot_r != 7'h40) boot_r <= boot_r + 7'h01;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  spi_mode_a: assert property (spi_req && !(production_program_mode && mpu_halted) |=> ext_refused)
    else $error("spi access outside program mode not refused");
  one_answer_a: assert property (ext_req |=> ext_done != ext_refused)
    else $error("ext request without exactly one answer");
  no_stray_a: assert property ((ext_done || ext_refused) |-> $past(ext_req))
    else $error("ext answer without request");
  key_lock_a: assert property (ext_req && ext_op != FWS_OP_READ && key_r != 4'h2 |=> ext_refused)
    else $error("flash change accepted without key");
  boot_hold_a: assert property (emu_grant == (boot_r >= 7'h20))
    else $error("emulator grant at wrong boot cycle");
  emu_hold_a: assert property (emu_req && !emu_grant |=> ext_refused)
    else $error("emulator served before grant");
  erase_wo_a: assert property (cpu_rd && cpu_addr == 16'h0094 |=> cpu_rdata == 8'h00)
    else $error("erase command register readable");
  secure_emu_a: assert property (emu_req && sec_r && ext_op != FWS_OP_MASS |=> ext_refused)
    else $error("secure emulator op other than mass erase accepted");
  secure_spi_a: assert property (spi_req && sec_r && ext_op == FWS_OP_READ |=> ext_refused)
    else $error("secure spi read accepted");
  secure_pg0_a: assert property (ext_req && sec_r && page_hit && ext_addr[15:10] == 6'h00
    |=> ext_refused)
    else $error("secure page zero change accepted");
  secure_base_a: assert property (ext_req && sec_r && ext_op == FWS_OP_PAGE
    && ext_addr[15:10] >= base_r |=> ext_refused)
    else $error("secure erase of engine code accepted");
endmodule : fws_properties

//--- bench/tb.sv
`timescale 1ns/1ps
`include "fws_regs.svh"
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] usr_addr = 4'h0;
  logic [15:0] usr_wdata = 16'h0000;
  logic usr_wr = 1'b0;
  logic usr_rd = 1'b0;
  logic [15:0] usr_rdata;
  logic ea = 1'b0;
  logic ce_enable = 1'b0;
  logic ce_busy = 1'b0;
  logic emu_en = 1'b0;
  logic production_program_mode = 1'b1;
  logic mpu_halted = 1'b1;
  logic boot_done;
  logic secure;
  logic [15:0] st;
  int n_fail = 0;
  int n_checks = 0;
  int n_ram = 0;
  logic [15:0] ram_seen = 16'h0000;
  always #20 mclk = ~mclk;
  // count stores steered to data ram
  always @(posedge mclk) begin
    if (bus.ram_wr === 1'b1) begin
      n_ram <= n_ram + 1;
      ram_seen <= {bus.ram_addr[7:0], bus.ram_data};
    end
  end
  fws_if bus ();
  fws_device #(.FLASH_BYTES(4096)) fws_device_inst (.mclk(mclk), .resetn(resetn), .bus(bus),
    .boot_done(boot_done), .secure(secure));
  fws_host fws_host_inst (.mclk(mclk), .resetn(resetn), .bus(bus), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata), .ea(ea),
    .ce_enable(ce_enable), .ce_busy(ce_busy), .emu_en(emu_en), .production_program_mode(production_program_mode),
    .mpu_halted(mpu_halted));
  fws_properties fws_properties_inst (.mclk(mclk), .resetn(resetn), .cpu_addr(bus.cpu_addr),
    .cpu_wdata(bus.cpu_wdata), .cpu_wr(bus.cpu_wr), .cpu_rd(bus.cpu_rd),
    .cpu_rdata(bus.cpu_rdata), .emu_grant(bus.emu_grant), .production_program_mode(bus.production_program_mode),
    .mpu_halted(bus.mpu_halted), .ext_req(bus.ext_req), .ext_src(bus.ext_src),
    .ext_op(bus.ext_op), .ext_addr(bus.ext_addr), .ext_done(bus.ext_done),
    .ext_refused(bus.ext_refused));
  // ==========================================
  // access tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic uw(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    usr_addr <= a;
    usr_wdata <= d;
    usr_wr <= 1'b1;
    @(posedge mclk);
    usr_wr <= 1'b0;
  endtask : uw
  task automatic ur(input logic [3:0] a);
    @(posedge mclk);
    usr_addr <= a;
    usr_rd <= 1'b1;
    @(posedge mclk);
    usr_rd <= 1'b0;
    #1 st = usr_rdata;
  endtask : ur
  task automatic cmd(input logic [3:0] c, input logic [15:0] a, input logic [15:0] d);
    uw(`FWS_H_ADDR, a);
    uw(`FWS_H_DATA, d);
    uw(`FWS_H_CMD, {12'h000, c});
    repeat (5) @(posedge mclk);
    ur(`FWS_H_STAT);
  endtask : cmd
  task automatic frd(input logic [15:0] a, input logic [7:0] e);
    cmd(`FWS_C_FREAD, a, 16'h0000);
    chk("flash byte", {8'h00, st[7:0]}, {8'h00, e});
  endtask : frd
  task automatic rreg(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    cmd(`FWS_C_RDREG, a, 16'h0000);
    chk("register", {8'h00, st[7:0] & m}, {8'h00, e});
  endtask : rreg
  task automatic wb(input logic [15:0] a, input logic [7:0] d);
    cmd(`FWS_C_WRITE, a, {8'h00, d});
  endtask : wb
  task automatic xop(input logic [15:0] a, input logic s, input logic [1:0] op,
                     input logic [7:0] d, input logic r);
    cmd(`FWS_C_EXT, a, {5'h00, s, op, d});
    chk("ext refused", {15'h0000, st[14]}, {15'h0000, r});
  endtask : xop
  task automatic rst();
    resetn <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1;
  endtask : rst
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // ==========================================
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("watchdog expired");
    complete_run();
  end
  // ==========================================
  // tests
  initial begin
    rst();
    chk("boot done", {15'h0000, boot_done}, 16'h0000);
    xop(16'h0000, 1'b0, 2'h0, 8'h00, 1'b1);
    rreg(`FWS_ADDR_CTRL, 8'hc0, 8'h80);
    repeat (70) @(posedge mclk);
    #1;
    chk("boot done", {15'h0000, boot_done}, 16'h0001);
    rreg(`FWS_ADDR_CTRL, 8'h80, 8'h00);
    $display("test boot done");
    xop(16'h0000, 1'b1, 2'h3, 8'h00, 1'b1);
    cmd(`FWS_C_UNLOCK, 16'h0000, 16'h0000);
    xop(16'h0000, 1'b1, 2'h3, 8'h00, 1'b0);
    frd(16'h0123, 8'hff);
    rreg(`FWS_ADDR_ERASE, 8'hff, 8'h00);
    production_program_mode <= 1'b0;
    xop(16'h0123, 1'b1, 2'h0, 8'h00, 1'b1);
    $display("test key and spi done");
    wb(16'h0405, 8'h5a);
    frd(16'h0405, 8'h5a);
    rreg(`FWS_ADDR_CTRL, 8'h01, 8'h00);
    ea <= 1'b1;
    wb(16'h0407, 8'h33);
    ea <= 1'b0;
    frd(16'h0407, 8'hff);
    chk("ram stores", n_ram[15:0], 16'h0001);
    chk("ram store", ram_seen, 16'h0733);
    cmd(`FWS_C_LOCK, 16'h0000, 16'h0000);
    wb(16'h0406, 8'h11);
    frd(16'h0406, 8'hff);
    cmd(`FWS_C_UNLOCK, 16'h0000, 16'h0000);
    rreg(`FWS_ADDR_KEY, 8'hf0, 8'h20);
    wb(16'h0805, 8'h66);
    production_program_mode <= 1'b1;
    xop(16'h0400, 1'b1, 2'h2, 8'h00, 1'b0);
    frd(16'h0405, 8'hff);
    frd(16'h0805, 8'h66);
    xop(16'h0c10, 1'b1, 2'h1, 8'h3c, 1'b0);
    xop(16'h0c10, 1'b1, 2'h0, 8'h00, 1'b0);
    chk("spi read", {8'h00, st[7:0]}, 16'h003c);
    $display("test write and page erase done");
    production_program_mode <= 1'b0;
    cmd(`FWS_C_PAGE, 16'h0800, 16'h0000);
    frd(16'h0805, 8'hff);
    cmd(`FWS_C_BASE, 16'h0000, 16'h0001);
    wb(16'h0400, 8'h34);
    wb(16'h0401, 8'h12);
    cmd(`FWS_C_CEREAD, 16'h0000, 16'h0000);
    ur(`FWS_H_CERES);
    chk("engine word", st, 16'h1234);
    ce_enable <= 1'b1;
    ce_busy <= 1'b1;
    wb(16'h0c01, 8'h42);
    wb(16'h0c02, 8'h43);
    frd(16'h0c01, 8'hff);
    rreg(`FWS_ADDR_CTRL, 8'h08, 8'h08);
    ce_busy <= 1'b0;
    ce_enable <= 1'b0;
    frd(16'h0c01, 8'h42);
    frd(16'h0c02, 8'hff);
    rreg(`FWS_ADDR_CTRL, 8'h08, 8'h00);
    $display("test engine done");
    cmd(`FWS_C_MASS, 16'h0000, 16'h0000);
    frd(16'h0400, 8'h34);
    emu_en <= 1'b1;
    cmd(`FWS_C_MASS, 16'h0000, 16'h0000);
    frd(16'h0400, 8'hff);
    $display("test mass erase done");
    wb(16'h0010, 8'h77);
    wb(16'h0805, 8'h66);
    cmd(`FWS_C_SECURE, 16'h0000, 16'h0000);
    rreg(`FWS_ADDR_CTRL, 8'h40, 8'h40);
    chk("secure", {15'h0000, secure}, 16'h0001);
    wb(16'h0011, 8'h22);
    frd(16'h0011, 8'hff);
    cmd(`FWS_C_PAGE, 16'h0000, 16'h0000);
    production_program_mode <= 1'b1;
    xop(16'h0000, 1'b1, 2'h2, 8'h00, 1'b1);
    xop(16'h0800, 1'b1, 2'h2, 8'h00, 1'b1);
    xop(16'h0010, 1'b1, 2'h0, 8'h00, 1'b1);
    xop(16'h0c00, 1'b0, 2'h1, 8'h01, 1'b1);
    frd(16'h0010, 8'h77);
    frd(16'h0805, 8'h66);
    xop(16'h0000, 1'b0, 2'h3, 8'h00, 1'b0);
    frd(16'h0010, 8'hff);
    chk("secure", {15'h0000, secure}, 16'h0001);
    rst();
    chk("secure", {15'h0000, secure}, 16'h0000);
    $display("test security done");
    complete_run();
  end
endmodule : tb
